// ==== include/fsp_pkg.sv ====
// Constants and types shared by the flash self-programming sequencer
package fsp_pkg;
  localparam int ROW_WORDS = 64;
  localparam int ROW_BYTES = 192;
  localparam int PAGE_ROWS = 8;
  localparam int PAGE_WORDS = 512;
  localparam int PAGE_BYTES = 1536;
  localparam int INSTR_W = 24;
  localparam int ADDR_W = 24;
  localparam int DADDR_W = 16;
  // Program addresses step by two per instruction word
  localparam logic [23:0] PAGE_ADDR_SPAN = 24'h000400;
  localparam logic [23:0] ROW_ADDR_SPAN = 24'h000080;
  localparam int CTL_START_BIT = 15;
  localparam int CTL_FORMAT_BIT = 9;
  localparam int CTL_OP_LSB = 0;
  localparam logic [3:0] OP_DWORD = 4'h1;
  localparam logic [3:0] OP_ROW = 4'h2;
  localparam logic [3:0] OP_PAGE = 4'h3;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [5:0] {
    FSP_IDLE = 6'h01,
    FSP_ERASE = 6'h02,
    FSP_DWORD = 6'h04,
    FSP_FETCH = 6'h08,
    FSP_WRITE = 6'h10,
    FSP_DONE = 6'h20
  } fsp_state_t;
endpackage

// ==== hw/fsp_fifo.sv ====
// Synchronous FIFO used between data memory fetch and the flash write port
`timescale 1ns/100ps
module fsp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] fill = wr_ptr - rd_ptr;
  // Pointers carry one extra bit, so a full count of DEPTH needs the full width
  assign in_ready = (fill != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (fill != '0) && !flush;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule

// ==== hw/fsp_sequencer.sv ====
// Run-time self-programming sequencer: unlock, erase, double-word and row programming
`timescale 1ns/100ps
module fsp_sequencer #(
  parameter int ROW_WORDS = fsp_pkg::ROW_WORDS,
  parameter int DEPTH = fsp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctl_wr,
  input wire logic [15:0] ctl_wdata,
  output logic [15:0] flash_control_reg,
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  input wire logic dest_wr,
  input wire logic [23:0] dest_wdata,
  output logic [23:0] flash_dest_address,
  input wire logic src_wr,
  input wire logic [15:0] src_wdata,
  output logic [15:0] row_source_address,
  input wire logic latch_wr,
  input wire logic latch_sel,
  input wire logic [23:0] latch_wdata,
  output logic cpu_stall,
  output logic dmem_req,
  output logic [15:0] dmem_addr,
  input wire logic dmem_ack,
  input wire logic [15:0] dmem_rdata,
  output logic fl_erase,
  output logic fl_prog,
  output logic [23:0] fl_addr,
  output logic [47:0] fl_wdata,
  input wire logic fl_done
);
  fsp_pkg::fsp_state_t state;
  fsp_pkg::fsp_state_t next_state;
  logic [1:0] key_stage;
  logic unlocked;
  logic compressed;
  logic [3:0] op_sel;
  logic [23:0] latch0;
  logic [23:0] latch1;
  logic [1:0] fetch_phase;
  logic [15:0] hold0;
  logic [15:0] hold1;
  logic [7:0] asm_words;
  logic [7:0] wr_words;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [23:0] fifo_in_data;
  logic fifo_out_valid;
  logic [23:0] fifo_out_data;
  logic fifo_flush;
  logic pair_half;
  logic [23:0] pair_lo;
  wire idle = (state == fsp_pkg::FSP_IDLE);
  wire start_req = ctl_wr && ctl_wdata[fsp_pkg::CTL_START_BIT] && idle;
  wire start_ok = start_req && unlocked;
  wire [3:0] req_op = ctl_wdata[fsp_pkg::CTL_OP_LSB +: 4];
  wire op_fin = (state == fsp_pkg::FSP_DONE);
  // Uncompressed: lo16, hi8 per word; compressed: w0, shared top bytes w1, w2
  wire [1:0] last_phase = compressed ? 2'h2 : 2'h1;
  wire dmem_take = dmem_req && dmem_ack;
  wire asm_fire = dmem_take && fetch_phase == last_phase;
  wire [5:0] word_mask = compressed ? 6'h02 : 6'h01;
  assign fifo_flush = idle;
  wire fetching = (state == fsp_pkg::FSP_FETCH) || (state == fsp_pkg::FSP_WRITE);
  assign dmem_req = fetching && asm_words < 8'(ROW_WORDS) && fifo_in_ready;
  assign dmem_addr = row_source_address;
  // Each instruction leaves as soon as its last word arrives; earlier words of the group wait in hold0 and hold1 until then
  logic [23:0] emit_word;
  logic emit_valid;
  always_comb
  begin
    emit_valid = 1'b0;
    emit_word = '0;
    if (dmem_take && fetch_phase == 2'h1)
    begin
      emit_valid = 1'b1;
      emit_word = {dmem_rdata[7:0], hold0};
    end
    else if (dmem_take && fetch_phase == 2'h2)
    begin
      emit_valid = 1'b1;
      emit_word = {hold1[15:8], dmem_rdata};
    end
  end
  assign fifo_in_valid = emit_valid;
  assign fifo_in_data = emit_word;
  wire pair_done = fifo_out_valid && pair_half;
  wire fl_ready = (state == fsp_pkg::FSP_WRITE) && !fl_prog;
  fsp_fifo #(.WIDTH(24), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fl_ready),
    .out_data(fifo_out_data)
  );
  always_comb
  begin
    next_state = state;
    unique case (state)
      fsp_pkg::FSP_IDLE:
        if (start_ok)
          next_state = (req_op == fsp_pkg::OP_PAGE) ? fsp_pkg::FSP_ERASE :
                       (req_op == fsp_pkg::OP_ROW) ? fsp_pkg::FSP_FETCH :
                       (req_op == fsp_pkg::OP_DWORD) ? fsp_pkg::FSP_DWORD : fsp_pkg::FSP_IDLE;
      fsp_pkg::FSP_ERASE, fsp_pkg::FSP_DWORD:
        if (fl_done)
          next_state = fsp_pkg::FSP_DONE;
      fsp_pkg::FSP_FETCH:
        next_state = fsp_pkg::FSP_WRITE;
      fsp_pkg::FSP_WRITE:
        if (fl_prog && fl_done && wr_words == 8'(ROW_WORDS - 2))
          next_state = fsp_pkg::FSP_DONE;
      fsp_pkg::FSP_DONE:
        next_state = fsp_pkg::FSP_IDLE;
      default:
        next_state = fsp_pkg::FSP_IDLE;
    endcase
  end
  assign cpu_stall = !idle;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      key_stage <= 2'h0;
    else if (key_wr)
      key_stage <= (key_wdata == fsp_pkg::KEY_FIRST) ? 2'h1 :
                   (key_wdata == fsp_pkg::KEY_SECOND && key_stage == 2'h1) ? 2'h2 : 2'h0;
    else if (ctl_wr)
      key_stage <= 2'h0;
  end
  assign unlocked = (key_stage == 2'h2);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= fsp_pkg::FSP_IDLE;
      compressed <= 1'b0;
      op_sel <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (ctl_wr && idle)
      begin
        compressed <= ctl_wdata[fsp_pkg::CTL_FORMAT_BIT];
        op_sel <= req_op;
      end
    end
  end
  // Start bit reads set only while an accepted operation runs
  assign flash_control_reg = {!idle, 5'h00, compressed, 5'h00, op_sel};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch0 <= '0;
      latch1 <= '0;
    end
    else if (latch_wr && idle)
    begin
      if (latch_sel)
        latch1 <= latch_wdata;
      else
        latch0 <= latch_wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_source_address <= '0;
      fetch_phase <= 2'h0;
      hold0 <= '0;
      hold1 <= '0;
      asm_words <= '0;
    end
    else if (idle)
    begin
      fetch_phase <= 2'h0;
      asm_words <= '0;
      if (src_wr)
        row_source_address <= src_wdata;
    end
    else
    begin
      if (dmem_take)
      begin
        row_source_address <= row_source_address + 16'h0002;
        fetch_phase <= (fetch_phase == last_phase) ? 2'h0 : fetch_phase + 2'h1;
        if (fetch_phase == 2'h0)
          hold0 <= dmem_rdata;
        if (fetch_phase == 2'h1)
          hold1 <= dmem_rdata;
        if (asm_fire)
          asm_words <= asm_words + {2'h0, word_mask};
      end
    end
  end
  // Destination: row programs step two words per pair; erase aligns to the page
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_dest_address <= '0;
      fl_erase <= 1'b0;
      fl_prog <= 1'b0;
      fl_addr <= '0;
      fl_wdata <= '0;
      pair_half <= 1'b0;
      pair_lo <= '0;
      wr_words <= '0;
    end
    else
    begin
      if (idle && dest_wr)
        flash_dest_address <= dest_wdata;
      if (idle)
      begin
        pair_half <= 1'b0;
        wr_words <= '0;
      end
      if (start_ok && req_op == fsp_pkg::OP_PAGE)
      begin
        fl_erase <= 1'b1;
        fl_addr <= flash_dest_address & ~(fsp_pkg::PAGE_ADDR_SPAN - 24'h1);
      end
      if (start_ok && req_op == fsp_pkg::OP_DWORD)
      begin
        fl_prog <= 1'b1;
        fl_addr <= {flash_dest_address[23:2], 2'h0};
        fl_wdata <= {latch1, latch0};
      end
      if (state == fsp_pkg::FSP_FETCH)
        fl_addr <= flash_dest_address & ~(fsp_pkg::ROW_ADDR_SPAN - 24'h1);
      if (fl_ready && fifo_out_valid)
      begin
        pair_half <= !pair_half;
        pair_lo <= fifo_out_data;
        if (pair_done)
        begin
          fl_prog <= 1'b1;
          fl_wdata <= {fifo_out_data, pair_lo};
        end
      end
      if (fl_done && (fl_erase || fl_prog))
      begin
        fl_erase <= 1'b0;
        fl_prog <= 1'b0;
        if (state == fsp_pkg::FSP_WRITE)
        begin
          wr_words <= wr_words + 8'h02;
          fl_addr <= fl_addr + 24'h000004;
          flash_dest_address <= flash_dest_address + 24'h000004;
        end
      end
    end
  end
  property p_stall_busy;
    @(posedge clk) disable iff (!rst_n) !idle |-> cpu_stall;
  endproperty
  a_stall_busy: assert property (p_stall_busy) else $error("stall low while busy");
  property p_no_key;
    @(posedge clk) disable iff (!rst_n) (start_req && !unlocked) |=> idle && !fl_prog && !fl_erase;
  endproperty
  a_no_key: assert property (p_no_key) else $error("locked start accepted");
  property p_start_clear;
    @(posedge clk) disable iff (!rst_n) op_fin |=> !flash_control_reg[15];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");
  property p_erase_align;
    @(posedge clk) disable iff (!rst_n) fl_erase |-> fl_addr[9:0] == 10'h000;
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("erase not page aligned");
  property p_unlock_needed;
    @(posedge clk) disable iff (!rst_n) $rose(cpu_stall) |-> $past(unlocked);
  endproperty
  a_unlock_needed: assert property (p_unlock_needed) else $error("ran without unlock");
  property p_src_step;
    @(posedge clk) disable iff (!rst_n)
      dmem_take |=> row_source_address == $past(row_source_address) + 16'h0002;
  endproperty
  a_src_step: assert property (p_src_step) else $error("source not stepped");
  property p_dword_data;
    @(posedge clk) disable iff (!rst_n) $rose(fl_prog) && state == fsp_pkg::FSP_DWORD
      |-> fl_wdata == {latch1, latch0};
  endproperty
  a_dword_data: assert property (p_dword_data) else $error("latched pair mismatch");
  property p_row_count;
    @(posedge clk) disable iff (!rst_n) wr_words <= 8'(ROW_WORDS);
  endproperty
  a_row_count: assert property (p_row_count) else $error("row overrun");
  c_erase: cover property (@(posedge clk) disable iff (!rst_n) state == fsp_pkg::FSP_ERASE);
  c_dword: cover property (@(posedge clk) disable iff (!rst_n) state == fsp_pkg::FSP_DWORD);
  c_row: cover property (@(posedge clk) disable iff (!rst_n)
    state == fsp_pkg::FSP_WRITE && next_state == fsp_pkg::FSP_DONE);
endmodule

// ==== tb/fsp_flash_model.sv ====
// Flash array and data memory stand-in facing the sequencer
`timescale 1ns/100ps
module fsp_flash_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic fl_erase,
  input wire logic fl_prog,
  output logic fl_done,
  input wire logic dmem_req,
  input wire logic [15:0] dmem_addr,
  output logic dmem_ack,
  output logic [15:0] dmem_rdata
);
  logic [3:0] cnt;
  logic tick;
  wire busy = fl_erase | fl_prog;
  wire hit = busy && !fl_done && cnt == (slow ? 4'hB : 4'h1);
  wire give = dmem_req && !dmem_ack && (!slow || tick);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      tick <= 1'b0;
      fl_done <= 1'b0;
      dmem_ack <= 1'b0;
      dmem_rdata <= 16'h0000;
    end
    else
    begin
      // One done pulse ends each erase or double-word write
      fl_done <= hit;
      cnt <= (hit || !busy) ? 4'h0 : cnt + 4'h1;
      tick <= ~tick;
      dmem_ack <= give;
      // Data toggles outside an ack so a stale word never looks valid
      dmem_rdata <= give ? {~dmem_addr[7:0], dmem_addr[8:1]} : ~dmem_rdata;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/100ps
module testbench;
  logic clk, rst_n, ctl_wr, key_wr, dest_wr, src_wr, latch_wr, latch_sel, slow;
  logic [15:0] ctl_wdata, src_wdata, row_source_address, flash_control_reg;
  logic [15:0] dmem_addr, dmem_rdata;
  logic [7:0] key_wdata;
  logic [23:0] dest_wdata, latch_wdata, flash_dest_address, fl_addr;
  logic [47:0] fl_wdata;
  logic cpu_stall, dmem_req, dmem_ack, fl_erase, fl_prog, fl_done;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_done = 0;
  logic [71:0] seen[$];

  fsp_sequencer #(.ROW_WORDS(64), .DEPTH(16)) dut_u (
    .clk(clk), .rst_n(rst_n), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .flash_control_reg(flash_control_reg), .key_wr(key_wr), .key_wdata(key_wdata),
    .dest_wr(dest_wr), .dest_wdata(dest_wdata), .flash_dest_address(flash_dest_address),
    .src_wr(src_wr), .src_wdata(src_wdata), .row_source_address(row_source_address),
    .latch_wr(latch_wr), .latch_sel(latch_sel), .latch_wdata(latch_wdata),
    .cpu_stall(cpu_stall), .dmem_req(dmem_req), .dmem_addr(dmem_addr),
    .dmem_ack(dmem_ack), .dmem_rdata(dmem_rdata), .fl_erase(fl_erase),
    .fl_prog(fl_prog), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_done(fl_done));

  fsp_flash_model model_u (
    .clk(clk), .rst_n(rst_n), .slow(slow), .fl_erase(fl_erase), .fl_prog(fl_prog),
    .fl_done(fl_done), .dmem_req(dmem_req), .dmem_addr(dmem_addr),
    .dmem_ack(dmem_ack), .dmem_rdata(dmem_rdata));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] word(input logic [15:0] a);
    return {~a[7:0], a[8:1]};
  endfunction

  task automatic summarize;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (fl_done && (fl_erase | fl_prog))
    begin
      n_done++;
      seen.push_back({fl_addr, fl_wdata});
    end
    if (cycles == 40000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Kinds: 0 key, 1 control, 2 destination, 3 source, 4 low latch, 5 high latch
  task automatic wr(input int k, input logic [23:0] d);
    @(posedge clk);
    key_wr <= k == 0;
    ctl_wr <= k == 1;
    dest_wr <= k == 2;
    src_wr <= k == 3;
    latch_wr <= k > 3;
    latch_sel <= k == 5;
    key_wdata <= d[7:0];
    ctl_wdata <= d[15:0];
    dest_wdata <= d;
    src_wdata <= d[15:0];
    latch_wdata <= d;
    @(posedge clk);
    {key_wr, ctl_wr, dest_wr, src_wr, latch_wr} <= 5'h00;
    #1;
  endtask

  task automatic run(input logic [15:0] ctl);
    int n;
    seen.delete();
    wr(0, 24'h000055);
    wr(0, 24'h0000AA);
    wr(1, {8'h00, ctl});
    chk(cpu_stall, 1'b1);
    chk(flash_control_reg, ctl);
    // The core issues nothing after the start while it waits for the stall to drop
    for (n = 0; n < 3000 && cpu_stall !== 1'b0; n++)
      @(posedge clk);
    #1;
    chk(flash_control_reg[15], 1'b0);
  endtask

  task automatic t_refuse;
    int n;
    n = n_done;
    wr(1, 24'h008003);
    chk({cpu_stall, flash_control_reg[15]}, 2'b00);
    wr(0, 24'h0000AA);
    wr(0, 24'h000055);
    wr(1, 24'h008003);
    chk({cpu_stall, flash_control_reg[15]}, 2'b00);
    // A plain control write spends the unlock
    wr(0, 24'h000055);
    wr(0, 24'h0000AA);
    wr(1, 24'h000003);
    wr(1, 24'h008003);
    repeat (4) @(posedge clk);
    #1;
    chk({cpu_stall, flash_control_reg[15]}, 2'b00);
    chk(n_done, n);
    $display("test refuse done");
  endtask

  task automatic t_erase;
    slow <= 1'b1;
    // Page three holds every later program target, so it is erased first
    wr(2, 24'h000C46);
    run(16'h8003);
    chk(seen.size(), 1);
    chk(seen[0][71:48], 24'h000C00);
    $display("test erase done");
  endtask

  task automatic t_dword;
    slow <= 1'b0;
    wr(4, 24'h123456);
    wr(5, 24'hABCDEF);
    wr(2, 24'h000C06);
    run(16'h8001);
    chk(seen.size(), 1);
    chk(seen[0][71:48], 24'h000C04);
    chk(seen[0][47:0], 48'hABCDEF123456);
    $display("test dword done");
  endtask

  task automatic t_row(input logic fmt);
    logic [15:0] a;
    logic [15:0] w0, w1, w2, w3;
    logic [23:0] base;
    slow <= fmt;
    // Each format gets its own erased row, so no word is programmed twice
    base = fmt ? 24'h000D00 : 24'h000C80;
    wr(3, 24'h000100);
    wr(2, base + 24'h000046);
    run(16'h8002 | {6'h00, fmt, 9'h000});
    chk(seen.size(), 32);
    chk(row_source_address, fmt ? 16'h01C0 : 16'h0200);
    chk(flash_dest_address, base + 24'h0000C6);
    for (int p = 0; p < 32 && p < seen.size(); p++)
    begin
      a = 16'h0100 + (fmt ? 16'(6 * p) : 16'(8 * p));
      w0 = word(a);
      w1 = word(a + 16'h0002);
      w2 = word(a + 16'h0004);
      w3 = word(a + 16'h0006);
      chk(seen[p][71:48], base + 24'(4 * p));
      if (fmt)
        chk(seen[p][47:0], {w1[15:8], w2, w1[7:0], w0});
      else
        chk(seen[p][47:0], {w3[7:0], w2, w1[7:0], w0});
    end
    $display("test row format %0d done", fmt);
  endtask

  initial
  begin
    rst_n = 1'b0;
    slow = 1'b0;
    {ctl_wr, key_wr, dest_wr, src_wr, latch_wr, latch_sel} = 6'h00;
    ctl_wdata = 16'h0000;
    key_wdata = 8'h00;
    dest_wdata = 24'h000000;
    src_wdata = 16'h0000;
    latch_wdata = 24'h000000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({cpu_stall, fl_erase, fl_prog, dmem_req, flash_control_reg}, 20'h00000);
    $display("test reset done");
    t_refuse();
    t_erase();
    t_dword();
    t_row(1'b0);
    t_row(1'b1);
    summarize();
  end
endmodule
